// >>> design/rtc_clock_prescale_divider.sv
// Real-time clock timebase: source select, prescalers, divider and AXI4-Lite registers
//
// What this block does
// - The tick prescaler divides the selected source by 1, 16, 64 or 256 for codes 00 to 11.
// - A separate power-control prescaler divides the same source with the same encoding.
// - The 16-bit period field sets the divider count period and an underflow ends each period.
// - The period register takes writes only while the unlock flag is 1, which software sets.
// - Control bits 10-8 and 3-2 read as zero and ignore writes.
//
// Our own choices: register access over AXI4-Lite and the register offsets.
module rtc_clock_prescale_divider
#(
  parameter int ADDR_W = 8
)
(
  input wire logic clk_in, // 50 MHz system clock
  input wire logic rst_in, // Asynchronous reset, active high
  input wire logic [3:0] src_pulse_in, // One-cycle pulses of the four clock sources
  output logic half_tick_out, // One-cycle half-second tick
  output logic pwr_tick_out, // One-cycle power-control tick
  output logic [4:0] fraction_trim_out, // Trim field, passed to the calendar
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready // Read data ready
);
  import rtc_prescale_pkg::*;

  // --------------------------------------------------
  // Declarations
  // --------------------------------------------------
  logic [15:0] ctrl_q;
  logic [15:0] period_q;
  logic unlock_q;
  logic [ADDR_W-1:0] waddr_q;
  logic aw_have_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic w_have_q;
  logic [1:0] bresp_q;
  logic bvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic rvalid_q;
  logic [7:0] psc_cnt_q;
  logic [7:0] pwr_cnt_q;
  logic [15:0] div_cnt_q;
  logic [15:0] tick_cnt_q;
  logic half_tick_q;
  logic pwr_tick_q;
  logic do_write;
  logic [7:0] wofs;
  logic [7:0] rofs;
  logic ctrl_wr;
  logic src_hit;
  logic pre_tick;
  logic pwr_hit;
  logic underflow;
  logic [15:0] wdata16;

  // Terminal count of a prescaler for a two-bit code
  function automatic logic [7:0] last_count(input logic [1:0] code);
    case (code)
      PSC_1: last_count = LAST_1;
      PSC_16: last_count = LAST_16;
      PSC_64: last_count = LAST_64;
      default: last_count = LAST_256;
    endcase
  endfunction

  // Word-aligned byte offset, low byte of the address
  function automatic logic [7:0] word_ofs(input logic [ADDR_W-1:0] a);
    logic [7:0] full;
    full = 8'(a);
    word_ofs = {full[7:2], 2'b00};
  endfunction

  // Merge strobed low bytes into an old 16-bit value
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // --------------------------------------------------
  // AXI write channel
  // --------------------------------------------------
  // Address and data are caught independently so either may come first
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready = !w_have_q && !bvalid_q;
  assign do_write = aw_have_q && w_have_q && !bvalid_q;
  assign wofs = word_ofs(waddr_q);
  assign wdata16 = merge16(16'h0000, wdata_q, wstrb_q);
  assign ctrl_wr = do_write && (wofs == CTRL_OFS);

  // Address holding register
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      aw_have_q <= 1'b0;
      waddr_q <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_have_q <= 1'b1;
      waddr_q <= s_axi_awaddr;
    end
    else if (do_write)
      aw_have_q <= 1'b0;
  end

  // Data holding register
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      w_have_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_have_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end
    else if (do_write)
      w_have_q <= 1'b0;
  end

  // Write response; unmapped offsets answer SLVERR
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= (wofs <= TICKCNT_OFS) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_q <= 1'b0;
  end
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // --------------------------------------------------
  // Software registers
  // --------------------------------------------------
  // Control: unimplemented bits are masked so they always stay zero
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      ctrl_q <= CTRL_RESET;
    else if (ctrl_wr)
      ctrl_q <= merge16(ctrl_q, wdata_q, wstrb_q) & CTRL_WMASK;
  end

  // Period: a locked write is dropped silently, the bus still sees OKAY
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      period_q <= PERIOD_RESET;
    else if (do_write && (wofs == PERIOD_OFS) && unlock_q)
      period_q <= merge16(period_q, wdata_q, wstrb_q);
  end

  // Unlock flag, plain read/write bit 0
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      unlock_q <= 1'b0;
    else if (do_write && (wofs == UNLOCK_OFS) && wstrb_q[0])
      unlock_q <= wdata16[0];
  end

  // --------------------------------------------------
  // AXI read channel
  // --------------------------------------------------
  assign s_axi_arready = !rvalid_q;
  assign rofs = word_ofs(s_axi_araddr);

  // One cycle from address handshake to data
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_q <= 1'b1;
      rresp_q <= RESP_OKAY;
      case (rofs)
        CTRL_OFS: rdata_q <= {16'h0000, ctrl_q};
        PERIOD_OFS: rdata_q <= {16'h0000, period_q};
        UNLOCK_OFS: rdata_q <= {31'h00000000, unlock_q};
        DIVCNT_OFS: rdata_q <= {16'h0000, div_cnt_q};
        TICKCNT_OFS: rdata_q <= {16'h0000, tick_cnt_q};
        default:
        begin
          rdata_q <= 32'h00000000;
          rresp_q <= RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
      rvalid_q <= 1'b0;
  end
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // --------------------------------------------------
  // Timebase
  // --------------------------------------------------
  // Source mux, then terminal compares of both prescalers
  assign src_hit = src_pulse_in[ctrl_q[SRC_LSB +: 2]];
  assign pre_tick = src_hit && (psc_cnt_q == last_count(ctrl_q[PS_LSB +: 2]));
  assign pwr_hit = src_hit && (pwr_cnt_q == last_count(ctrl_q[PWR_LSB +: 2]));
  assign underflow = pre_tick && (div_cnt_q == 16'h0000);

  // Prescalers restart on any control write so a new ratio starts clean
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      psc_cnt_q <= 8'h00;
      pwr_cnt_q <= 8'h00;
    end
    else if (ctrl_wr)
    begin
      psc_cnt_q <= 8'h00;
      pwr_cnt_q <= 8'h00;
    end
    else if (src_hit)
    begin
      psc_cnt_q <= pre_tick ? 8'h00 : psc_cnt_q + 8'h01;
      pwr_cnt_q <= pwr_hit ? 8'h00 : pwr_cnt_q + 8'h01;
    end
  end

  // Down counter: period+1 prescaled ticks per underflow; new period taken at reload
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      div_cnt_q <= PERIOD_RESET;
    else if (underflow)
      div_cnt_q <= period_q;
    else if (pre_tick)
      div_cnt_q <= div_cnt_q - 16'h0001;
  end

  // Registered tick outputs and the tick counter
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      half_tick_q <= 1'b0;
      pwr_tick_q <= 1'b0;
      tick_cnt_q <= 16'h0000;
    end
    else
    begin
      half_tick_q <= underflow;
      pwr_tick_q <= pwr_hit;
      if (underflow)
        tick_cnt_q <= tick_cnt_q + 16'h0001;
    end
  end
  assign half_tick_out = half_tick_q;
  assign pwr_tick_out = pwr_tick_q;
  assign fraction_trim_out = ctrl_q[TRIM_MSB:TRIM_LSB];

  // --------------------------------------------------
  // Assertions
  // --------------------------------------------------
  // Helper: source pulses seen since the last prescaled tick
  logic [8:0] since_q;
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      since_q <= 9'h000;
    else if (ctrl_wr || pre_tick)
      since_q <= 9'h000;
    else if (src_hit)
      since_q <= since_q + 9'h001;
  end

  a_tick_prescale_ratio: assert property (@(posedge clk_in) disable iff (rst_in)
    pre_tick |-> (since_q == {1'b0, last_count(ctrl_q[PS_LSB +: 2])}))
    else $error("tick prescaler fired after wrong number of source pulses");
  a_pwr_tick_follows: assert property (@(posedge clk_in) disable iff (rst_in)
    (src_hit && ctrl_q[PWR_LSB +: 2] == PSC_1) |=> pwr_tick_out)
    else $error("power prescaler at 1:1 missed a source pulse");
  a_divider_reload: assert property (@(posedge clk_in) disable iff (rst_in)
    underflow |=> (div_cnt_q == $past(period_q)) && half_tick_out)
    else $error("divider did not reload on underflow");
  a_divider_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    !pre_tick |=> $stable(div_cnt_q))
    else $error("divider moved without a prescaled tick");
  a_period_locked: assert property (@(posedge clk_in) disable iff (rst_in)
    !unlock_q |=> $stable(period_q))
    else $error("period changed while locked");
  a_ctrl_reserved: assert property (@(posedge clk_in) disable iff (rst_in)
    (ctrl_q[10:8] == 3'b000) && (ctrl_q[3:2] == 2'b00))
    else $error("unimplemented control bits not zero");
  a_half_tick_cause: assert property (@(posedge clk_in) disable iff (rst_in)
    half_tick_out |-> $past(pre_tick) && ($past(div_cnt_q) == 16'h0000))
    else $error("half tick without divider underflow");
  a_read_latency: assert property (@(posedge clk_in) disable iff (rst_in)
    (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
    else $error("read data not one cycle after address");
  c_half_tick: cover property (@(posedge clk_in) disable iff (rst_in) half_tick_out);
  c_locked_write: cover property (@(posedge clk_in) disable iff (rst_in)
    do_write && (wofs == PERIOD_OFS) && !unlock_q);
  c_ratio_256: cover property (@(posedge clk_in) disable iff (rst_in)
    pre_tick && (ctrl_q[PS_LSB +: 2] == 2'b11));
  c_back_to_back_read: cover property (@(posedge clk_in) disable iff (rst_in)
    s_axi_rvalid && s_axi_rready && s_axi_arvalid);
endmodule

// >>> design/rtc_prescale_pkg.sv
// Package: register map, field layout, reset values and prescale codes
package rtc_prescale_pkg;
  // --------------------------------------------------
  // Register byte offsets
  // --------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00; // clock_source_prescale_ctrl
  localparam logic [7:0] PERIOD_OFS = 8'h04; // tick_period_reload
  localparam logic [7:0] UNLOCK_OFS = 8'h08; // write_unlock_flag
  localparam logic [7:0] DIVCNT_OFS = 8'h0c; // Live divider count, read only
  localparam logic [7:0] TICKCNT_OFS = 8'h10; // Half-second tick count, read only

  // --------------------------------------------------
  // Field positions and reset values
  // --------------------------------------------------
  localparam int TRIM_LSB = 11;
  localparam int TRIM_MSB = 15;
  localparam int PWR_LSB = 6;
  localparam int PS_LSB = 4;
  localparam int SRC_LSB = 0;
  localparam logic [15:0] CTRL_WMASK = 16'hf8f3; // Bits 10-8 and 3-2 unimplemented
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] PERIOD_RESET = 16'h3fff;

  // --------------------------------------------------
  // Prescale codes and terminal counts
  // --------------------------------------------------
  localparam logic [1:0] PSC_1 = 2'b00;
  localparam logic [1:0] PSC_16 = 2'b01;
  localparam logic [1:0] PSC_64 = 2'b10;
  localparam logic [7:0] LAST_1 = 8'h00;
  localparam logic [7:0] LAST_16 = 8'h0f;
  localparam logic [7:0] LAST_64 = 8'h3f;
  localparam logic [7:0] LAST_256 = 8'hff;

  // --------------------------------------------------
  // AXI responses
  // --------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// >>> bench/rtc_clock_prescale_divider_tb.sv
// Testbench for the real-time clock timebase and its register bus
module rtc_clock_prescale_divider_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rtc_prescale_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [3:0] src_pulse_in = 4'h0;
  logic half_tick_out, pwr_tick_out, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [4:0] fraction_trim_out;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int num_errors = 0;
  int checked = 0;
  logic [1:0] rsp;
  logic [31:0] rd;

  // Clock at 50 MHz
  always #10 clk_in = ~clk_in;

  rtc_clock_prescale_divider rtc_clock_prescale_divider_i (.clk_in(clk_in), .rst_in(rst_in),
    .src_pulse_in(src_pulse_in), .half_tick_out(half_tick_out), .pwr_tick_out(pwr_tick_out),
    .fraction_trim_out(fraction_trim_out), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));

  // --------------------------------------------------
  // Reporting
  // --------------------------------------------------
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
    begin
      $display("bench passed");
    end
    else
    begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask

  // A hung handshake counts as a mismatch and closes the run
  task automatic hang(input int i);
    if (i > 60)
    begin
      $display("wrong value handshake expected done seen timeout");
      num_errors++;
      end_sim();
    end
  endtask

  // --------------------------------------------------
  // Bus cycles; handshakes sampled at the falling edge, where all is settled
  // --------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [15:0] d, output logic [1:0] r);
    int i;
    logic aw, w, b;
    i = 0;
    // One edge between transfers so a strobe is never assigned twice at one instant
    @(posedge clk_in);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {16'h0000, d};
    s_axi_wstrb <= 4'h3;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(negedge clk_in);
      aw = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk_in);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) s_axi_bready <= 1'b0;
      hang(++i);
    end
    while (!b);
  endtask

  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    logic ar, v;
    i = 0;
    @(posedge clk_in);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(negedge clk_in);
      ar = s_axi_arvalid & s_axi_arready;
      v = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk_in);
      if (ar) s_axi_arvalid <= 1'b0;
      if (v) s_axi_rready <= 1'b0;
      hang(++i);
    end
    while (!v);
  endtask

  // --------------------------------------------------
  // Scenarios
  // --------------------------------------------------
  task automatic t_reset();
    rdr(CTRL_OFS, rd, rsp);
    cmp("ctrl reset", {16'h0, CTRL_RESET}, rd);
    rdr(PERIOD_OFS, rd, rsp);
    cmp("period reset", {16'h0, PERIOD_RESET}, rd);
    rdr(8'h14, rd, rsp);
    cmp("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    cmp("unmapped data", 32'h0, rd);
    wr(8'h14, 16'h0000, rsp);
    cmp("unmapped wresp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    $display("test reset done");
  endtask

  // Unimplemented control bits must read zero after writing all ones
  task automatic t_ctrl();
    wr(CTRL_OFS, 16'hffff, rsp);
    rdr(CTRL_OFS, rd, rsp);
    cmp("ctrl readback", 32'h0000f8f3, rd);
    cmp("trim out", 32'h1f, {27'h0, fraction_trim_out});
    wr(CTRL_OFS, 16'h0000, rsp);
    $display("test ctrl done");
  endtask

  // Period is protected until the unlock flag is set
  task automatic t_lock();
    wr(PERIOD_OFS, 16'h0003, rsp);
    cmp("locked resp", {30'h0, RESP_OKAY}, {30'h0, rsp});
    rdr(PERIOD_OFS, rd, rsp);
    cmp("locked period", 32'h3fff, rd);
    wr(UNLOCK_OFS, 16'h0001, rsp);
    rdr(UNLOCK_OFS, rd, rsp);
    cmp("unlock flag", 32'h1, rd);
    wr(PERIOD_OFS, 16'h0003, rsp);
    rdr(PERIOD_OFS, rd, rsp);
    cmp("unlocked period", 32'h0003, rd);
    $display("test lock done");
  endtask

  // The divider drains its reset count before the new period takes over at reload;
  // one pulse more after the tick leaves the count at period 3 minus one
  task automatic t_first_tick();
    int k;
    k = 0;
    wr(CTRL_OFS, 16'h0000, rsp);
    src_pulse_in <= 4'h1;
    do
    begin
      @(posedge clk_in);
      k++;
      @(negedge clk_in);
    end
    while (half_tick_out !== 1'b1 && k < 20000);
    @(posedge clk_in);
    src_pulse_in <= 4'h0;
    cmp("first tick pulses", {16'h0, PERIOD_RESET} + 32'h1, k);
    if (k >= 20000)
    begin
      end_sim();
    end
    rdr(TICKCNT_OFS, rd, rsp);
    cmp("tick counter", 32'h1, rd);
    rdr(DIVCNT_OFS, rd, rsp);
    cmp("divider after reload", 32'h2, rd);
    $display("test first tick done");
  endtask

  // Selected source pulses every other cycle, the others in between; period 3 gives
  // four prescaled ticks per underflow, so 4*r source pulses between half ticks
  task automatic t_rate(input logic [1:0] c, input int r);
    int n, hs[$], ps[$];
    logic [3:0] sel;
    n = 0;
    sel = 4'h1 << c;
    wr(CTRL_OFS, {8'h00, c, c, 2'b00, c}, rsp);
    for (int i = 0; i < 32 * r + 64; i++)
    begin
      @(negedge clk_in);
      if (half_tick_out === 1'b1) hs.push_back(n);
      if (pwr_tick_out === 1'b1) ps.push_back(n);
      @(posedge clk_in);
      src_pulse_in <= i[0] ? sel : ~sel;
      n += i[0];
    end
    @(posedge clk_in);
    src_pulse_in <= 4'h0;
    if (hs.size() < 2 || ps.size() < 2)
    begin
      cmp("tick count", 32'h2, 32'h0);
    end
    else
    begin
      cmp("half interval", 4 * r, hs[1] - hs[0]);
      cmp("pwr interval", r, ps[1] - ps[0]);
    end
    $display("test rate code %0d done", c);
  endtask

  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_ctrl();
    t_lock();
    t_first_tick();
    t_rate(2'b00, 1);
    t_rate(2'b01, 16);
    t_rate(2'b10, 64);
    t_rate(2'b11, 256);
    end_sim();
  end
endmodule
